// ==== tgem_pkg.sv ====
/*
  Constants for the edge-to-edge measurement block.
  Assumes a 50 MHz system clock and 32-bit Avalon-MM register access.
*/
`default_nettype none
package tgem_pkg;
  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  localparam int unsigned SYS_HZ = 50_000_000;
  localparam int unsigned CNT_HZ = 12_000_000;
  localparam logic [7:0] TICK_STEP = 8'(CNT_HZ / 1_000_000);
  localparam logic [7:0] TICK_MOD = 8'(SYS_HZ / 1_000_000);
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_TACH0 = 5'h08;
  localparam logic [4:0] OFS_TACH1 = 5'h0c;
  localparam logic [4:0] OFS_GATE = 5'h10;
  // ----------------------------------------
  // Control fields and defaults
  // ----------------------------------------
  localparam int T1_START_LSB = 14;
  localparam int GATE_START_LSB = 12;
  localparam int T1_STOP_LSB = 6;
  localparam int TACH1_SELF_CLEAR_BIT = 4;
  localparam int T0_START_BIT = 3;
  localparam int T0_MODE_BIT = 1;
  localparam int T0_STALE_BIT = 0;
  localparam logic [15:0] CTRL_MASK = 16'hf0db;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int ST_T0_RUN_BIT = 2;
  localparam int ST_T1_RUN_BIT = 3;
  localparam int ST_GATE_RUN_BIT = 4;
  localparam int ST_T0_FRESH_BIT = 5;
  // ----------------------------------------
  // Edge select codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    TGEM_SEL_READY_FALL = 2'b00,
    TGEM_SEL_RESERVED = 2'b01,
    TGEM_SEL_IN_A = 2'b10,
    TGEM_SEL_IN_B = 2'b11
  } tgem_sel_t;
endpackage : tgem_pkg
`default_nettype wire

// ==== tgem_meas_if.sv ====
/*
  Link between the top and one measurement counter.
  Assumes all signals live on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface tgem_meas_if #(parameter int W = 32);
  logic tick;
  logic start;
  logic stop;
  logic push;
  logic self_clear;
  logic restart;
  logic [W-1:0] value;
  logic running;
  logic done;
  modport ctl (output tick, start, stop, push, self_clear, restart,
    input value, running, done);
  modport cnt (input tick, start, stop, push, self_clear, restart,
    output value, running, done);
endinterface : tgem_meas_if
`default_nettype wire

// ==== tgem_counter.sv ====
/*
  One edge-to-edge counter, counting on the 12 MHz tick enable.
  Assumes start and stop pulses are aligned to the tick.
*/
`timescale 1ns/1ps
`default_nettype none
module tgem_counter #(
  parameter int W = 32
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Control link
  tgem_meas_if.cnt m
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  assign next_count = (count == {W{1'b1}}) ? count : count + W'(1);

  // ----------------------------------------
  // Running count
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      m.running <= 1'b0;
    end else if (m.tick) begin
      if (m.running && m.stop) begin
        m.running <= m.restart;
        count <= W'(1);
      end else if (m.start) begin
        m.running <= 1'b1;
        count <= W'(1);
      end else if (m.running) begin
        count <= next_count;
      end
    end
  end

  // ----------------------------------------
  // Latched result
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      m.value <= '0;
      m.done <= 1'b0;
    end else begin
      m.done <= 1'b0;
      if (m.tick && m.running && m.stop) begin
        m.value <= next_count;
        m.done <= 1'b1;
      end else if (m.push && m.self_clear) begin
        m.value <= '0;
      end
    end
  end
endmodule : tgem_counter
`default_nettype wire

// ==== tgem_measure.sv ====
/*
  Tach and gate edge-to-edge measurement with an Avalon-MM register port.
  Assumes pins are asynchronous to clock and sample_push comes from
  logic on clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Gate start code 00 is sample-ready falling, 01 none, 10 gate falling, 11 gate rising.
// - Tach1 start code 00 is sample-ready falling, 01 none, 10 tach rising, 11 tach falling.
// - Tach1 stop code 00 is sample-ready falling, 01 none, 10 tach rising, 11 tach falling.
// - With tach1 self-clear set its reported value drops to zero after each push, or takes the new result if a tach1 measurement ends in that cycle.
// - Control bit 3 picks the tach0 edge, one for falling and zero for rising.
// - Control bit 1 makes tach0 report zero rather than the old result while measuring.
// - Control bit 0 enables the tach0 freshness flag in the result MSB.
// - With the flag enabled a new result shows MSB zero and an unrefreshed one MSB one.
// - With the flag disabled the tach0 result MSB is always zero.
// - Counting runs on a 12 MHz enable and a count N spans N minus one periods.
// - Control settings return to their defaults at every reset.
// - Tach1 start select sits in control bits 15 and 14.
// - Gate start select sits in control bits 13 and 12.
// - Tach1 self-clear sits in control bit 4.
module tgem_measure #(
  parameter int W = 32
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins
  input wire logic tach_in,
  input wire logic gate_in,
  input wire logic sample_ready,
  // Sample stream
  input wire logic sample_push,
  output logic stream_valid,
  output logic [W-1:0] stream_tach0,
  output logic [W-1:0] stream_tach1,
  output logic [W-1:0] stream_gate
);
  logic [15:0] ctrl;
  logic [7:0] phase;
  logic tick;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_d;
  logic [4:0] edge_now;
  logic [4:0] edge_held;
  logic tach_rise;
  logic tach_fall;
  logic gate_rise;
  logic gate_fall;
  logic ready_fall;
  logic tach0_fresh;
  logic [W-1:0] tach0_word;
  logic [31:0] status_word;
  logic [31:0] next_readdata;
  logic bus_take;
  logic [31:0] wmask;
  tgem_pkg::tgem_sel_t t1_start_sel;
  tgem_pkg::tgem_sel_t t1_stop_sel;
  tgem_pkg::tgem_sel_t gate_start_sel;
  logic tach1_self_clear;
  logic tach0_start_edge_sel;
  logic tach0_interim_mode;
  logic tach0_stale_enable;

  tgem_meas_if #(.W(W)) t0_if ();
  tgem_meas_if #(.W(W)) t1_if ();
  tgem_meas_if #(.W(W)) g_if ();

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  assign t1_start_sel =
    tgem_pkg::tgem_sel_t'(ctrl[tgem_pkg::T1_START_LSB +: 2]);
  assign gate_start_sel =
    tgem_pkg::tgem_sel_t'(ctrl[tgem_pkg::GATE_START_LSB +: 2]);
  assign t1_stop_sel =
    tgem_pkg::tgem_sel_t'(ctrl[tgem_pkg::T1_STOP_LSB +: 2]);
  assign tach1_self_clear = ctrl[tgem_pkg::TACH1_SELF_CLEAR_BIT];
  assign tach0_start_edge_sel = ctrl[tgem_pkg::T0_START_BIT];
  assign tach0_interim_mode = ctrl[tgem_pkg::T0_MODE_BIT];
  assign tach0_stale_enable = ctrl[tgem_pkg::T0_STALE_BIT];

  // ----------------------------------------
  // 12 MHz count enable
  // ----------------------------------------
  // Fractional divider: 12 ticks in every 50 clocks, never two in a row
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 8'h00;
      tick <= 1'b0;
    end else if (phase + tgem_pkg::TICK_STEP >= tgem_pkg::TICK_MOD) begin
      phase <= phase + tgem_pkg::TICK_STEP - tgem_pkg::TICK_MOD;
      tick <= 1'b1;
    end else begin
      phase <= phase + tgem_pkg::TICK_STEP;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {sample_ready, gate_in, tach_in};
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------
  // Edge detection at the system clock
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_d <= 3'h0;
    end else begin
      sync_d <= sync_b;
    end
  end

  // Bit order: ready fall, gate fall, gate rise, tach fall, tach rise
  assign edge_now = {~sync_b[2] & sync_d[2], ~sync_b[1] & sync_d[1],
                     sync_b[1] & ~sync_d[1], ~sync_b[0] & sync_d[0],
                     sync_b[0] & ~sync_d[0]};

  // ----------------------------------------
  // Edge hold until the next count enable
  // ----------------------------------------
  // A pin pulse shorter than an enable period is kept, not lost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      edge_held <= 5'h00;
    end else if (tick) begin
      edge_held <= edge_now;
    end else begin
      edge_held <= edge_held | edge_now;
    end
  end

  // One pulse per edge, standing until the enable that consumes it
  assign tach_rise = edge_held[0];
  assign tach_fall = edge_held[1];
  assign gate_rise = edge_held[2];
  assign gate_fall = edge_held[3];
  assign ready_fall = edge_held[4];

  // ----------------------------------------
  // Edge routing
  // ----------------------------------------
  function automatic logic pick_edge(input tgem_pkg::tgem_sel_t sel,
                                     input logic ready_edge,
                                     input logic code_a_edge,
                                     input logic code_b_edge);
    logic r;
    r = 1'b0;
    unique case (sel)
      tgem_pkg::TGEM_SEL_READY_FALL: r = ready_edge;
      tgem_pkg::TGEM_SEL_RESERVED: r = 1'b0;
      tgem_pkg::TGEM_SEL_IN_A: r = code_a_edge;
      tgem_pkg::TGEM_SEL_IN_B: r = code_b_edge;
    endcase
    return r;
  endfunction : pick_edge

  // Tach0 measures period: one edge both ends one interval and starts the next
  assign t0_if.tick = tick;
  assign t0_if.start = tach0_start_edge_sel ? tach_fall : tach_rise;
  assign t0_if.stop = t0_if.start;
  assign t0_if.restart = 1'b1;
  assign t0_if.push = sample_push;
  assign t0_if.self_clear = 1'b0;

  // Tach1 start and stop each pick one of three edges or none
  assign t1_if.tick = tick;
  assign t1_if.start =
    pick_edge(t1_start_sel, ready_fall, tach_rise, tach_fall);
  assign t1_if.stop =
    pick_edge(t1_stop_sel, ready_fall, tach_rise, tach_fall);
  assign t1_if.restart = 1'b0;
  assign t1_if.push = sample_push;
  assign t1_if.self_clear = tach1_self_clear;

  // Gate stop edge is the gate edge opposite to a gate start choice, or either gate edge after a ready-fall start
  assign g_if.tick = tick;
  assign g_if.start =
    pick_edge(gate_start_sel, ready_fall, gate_fall, gate_rise);
  assign g_if.stop =
    pick_edge(gate_start_sel, gate_fall | gate_rise, gate_rise, gate_fall);
  assign g_if.restart = 1'b0;
  assign g_if.push = sample_push;
  assign g_if.self_clear = 1'b0;

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  tgem_counter #(.W(W)) u_tach0 (
    .clock(clock),
    .rst_n(rst_n),
    .m(t0_if)
  );

  tgem_counter #(.W(W)) u_tach1 (
    .clock(clock),
    .rst_n(rst_n),
    .m(t1_if)
  );

  tgem_counter #(.W(W)) u_gate (
    .clock(clock),
    .rst_n(rst_n),
    .m(g_if)
  );

  // ----------------------------------------
  // Tach0 freshness
  // ----------------------------------------
  // A completion in the same cycle as a push keeps the flag set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tach0_fresh <= 1'b0;
    end else if (t0_if.done) begin
      tach0_fresh <= 1'b1;
    end else if (sample_push) begin
      tach0_fresh <= 1'b0;
    end
  end

  always_comb begin
    tach0_word = t0_if.value;
    if (t0_if.running && tach0_interim_mode && !tach0_fresh) begin
      tach0_word = '0;
    end
    if (tach0_stale_enable) begin
      tach0_word[W-1] = ~tach0_fresh;
    end else begin
      tach0_word[W-1] = 1'b0;
    end
  end

  // ----------------------------------------
  // Sample stream
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stream_valid <= 1'b0;
      stream_tach0 <= '0;
      stream_tach1 <= '0;
      stream_gate <= '0;
    end else begin
      // Words taken before a self-clear of the same push
      stream_valid <= sample_push;
      if (sample_push) begin
        stream_tach0 <= tach0_word;
        stream_tach1 <= t1_if.value;
        stream_gate <= g_if.value;
      end
    end
  end

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  assign bus_take = (avs_read || avs_write) && !avs_waitrequest;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always_comb begin
    status_word = 32'h00000000;
    status_word[tgem_pkg::ST_T0_RUN_BIT] = t0_if.running;
    status_word[tgem_pkg::ST_T1_RUN_BIT] = t1_if.running;
    status_word[tgem_pkg::ST_GATE_RUN_BIT] = g_if.running;
    status_word[tgem_pkg::ST_T0_FRESH_BIT] = tach0_fresh;
  end

  // ----------------------------------------
  // Wait state
  // ----------------------------------------
  // One wait cycle, then the answer at the edge where waitrequest is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Reserved bits are masked off, so they always read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= tgem_pkg::CTRL_RESET;
    end else if (bus_take && avs_write && avs_address == tgem_pkg::OFS_CTRL) begin
      ctrl <= ((ctrl & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]))
              & tgem_pkg::CTRL_MASK;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    next_readdata = 32'h00000000;
    unique case (avs_address)
      tgem_pkg::OFS_CTRL: next_readdata = {16'h0000, ctrl};
      tgem_pkg::OFS_STATUS: next_readdata = status_word;
      tgem_pkg::OFS_TACH0: next_readdata = 32'(tach0_word);
      tgem_pkg::OFS_TACH1: next_readdata = 32'(t1_if.value);
      tgem_pkg::OFS_GATE: next_readdata = 32'(g_if.value);
      default: next_readdata = 32'h00000000;
    endcase
  end

  // Data registered on the wait cycle so it stands at the completing edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end
endmodule : tgem_measure
`default_nettype wire

// ==== tgem_measure_sva.sv ====
/*
  Port checker for the edge-to-edge measurement block.
  Assumes one bus access at a time, as the bench drives it.
*/
`timescale 1ns/1ps
`default_nettype none
module tgem_measure_sva #(
  parameter int W = 32
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Stream
  input wire logic sample_push,
  input wire logic stream_valid,
  input wire logic [W-1:0] stream_tach0,
  input wire logic [W-1:0] stream_tach1,
  input wire logic [W-1:0] stream_gate
);
  // ----------------------------------------
  // Shadow of the control register
  // ----------------------------------------
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (avs_byteenable[0]) next_ctrl[7:0] = avs_writedata[7:0];
    if (avs_byteenable[1]) next_ctrl[15:8] = avs_writedata[15:8];
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 16'h0000;
    end else if (avs_write && !avs_waitrequest && avs_address == tgem_pkg::OFS_CTRL) begin
      ctrl <= next_ctrl & tgem_pkg::CTRL_MASK;
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus stall not exactly one cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_idle_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  ctrl_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 5'h00 |-> avs_readdata == {16'h0000, ctrl})
    else $error("control readback wrong");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && !(avs_address inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10}) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  valid_push_a: assert property (sample_push |=> stream_valid)
    else $error("no stream word after push");
  valid_cause_a: assert property (stream_valid |-> $past(sample_push))
    else $error("stream word without push");
  words_hold_a: assert property (!stream_valid |-> $stable({stream_tach0, stream_tach1, stream_gate}))
    else $error("stream words moved between pushes");
  stale_off_a: assert property (stream_valid && !$past(ctrl[0]) |-> !stream_tach0[W-1])
    else $error("tach0 msb set with flag disabled");
endmodule : tgem_measure_sva
bind tgem_measure tgem_measure_sva #(.W(W)) tgem_measure_sva_i (.clock(clock), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sample_push(sample_push), .stream_valid(stream_valid), .stream_tach0(stream_tach0),
  .stream_tach1(stream_tach1), .stream_gate(stream_gate));
`default_nettype wire

// ==== tgem_pin_source.sv ====
/*
  Tach, gate and sample-ready sources with a common period.
  Assumes run low freezes every pin at its idle level.
*/
`timescale 1ns/1ps
`default_nettype none
module tgem_pin_source #(
  parameter int PERIOD = 100,
  parameter int TACH_HIGH = 30,
  parameter int GATE_RISE = 10,
  parameter int GATE_FALL = 40
) (
  // System
  input wire logic clock,
  input wire logic run,
  // Pins
  output logic tach_in,
  output logic gate_in,
  output logic sample_ready
);
  int phase = 0;
  initial begin
    tach_in = 1'b0;
    gate_in = 1'b0;
    sample_ready = 1'b1;
  end
  // Ready falls together with the tach rise
  always @(posedge clock) begin
    if (!run) begin
      phase <= 0;
      tach_in <= 1'b0;
      gate_in <= 1'b0;
      sample_ready <= 1'b1;
    end else begin
      phase <= (phase + 1) % PERIOD;
      tach_in <= phase < TACH_HIGH;
      gate_in <= phase >= GATE_RISE && phase < GATE_FALL;
      sample_ready <= phase >= 2;
    end
  end
endmodule : tgem_pin_source
`default_nettype wire

// ==== tach_gate_edge_measure_bench.sv ====
/*
  Self-checking bench for the measurement block.
  Assumes the pin source model and a 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tach_gate_edge_measure_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tach_in, gate_in, sample_ready, stream_valid;
  logic sample_push = 1'b0;
  logic run = 1'b0;
  logic [31:0] stream_tach0, stream_tach1, stream_gate;
  logic [31:0] rd, wd, t0, t1, g, t0b, t1b, gb;
  logic [15:0] ctrl_m;
  logic [3:0] be;
  int i;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'ha767;
  int t1_start[6] = '{2, 1, 3, 3, 0, 2};
  int t1_stop[6] = '{3, 3, 2, 0, 3, 1};
  int t1_clocks[6] = '{30, 0, 70, 70, 30, 0};
  int gate_start[6] = '{0, 2, 3, 1, 2, 3};
  int gate_clocks[6] = '{10, 70, 30, 30, 70, 30};
  int t1_run[6] = '{0, 0, 1, 1, 0, 1};
  int gate_run[6] = '{0, 1, 0, 0, 1, 0};
  always #10 clock = ~clock;
  tgem_measure #(.W(32)) tgem_measure_i (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tach_in(tach_in),
    .gate_in(gate_in), .sample_ready(sample_ready), .sample_push(sample_push),
    .stream_valid(stream_valid), .stream_tach0(stream_tach0), .stream_tach1(stream_tach1),
    .stream_gate(stream_gate));
  tgem_pin_source tgem_pin_source_i (.clock(clock), .run(run), .tach_in(tach_in),
    .gate_in(gate_in), .sample_ready(sample_ready));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic check(string what, logic [31:0] exp, logic [31:0] got, int tol);
    checks_done++;
    if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check
  // Count for an interval of so many system clocks
  function automatic int cnt_of(int clocks);
    return (clocks == 0) ? 0 : clocks * 12 / 50 + 1;
  endfunction : cnt_of
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
  endtask : do_reset
  task automatic bus(logic wr, logic [4:0] adr, logic [31:0] dat, logic [3:0] ben,
                     output logic [31:0] rdat);
    int n;
    avs_address <= adr;
    avs_writedata <= dat;
    avs_byteenable <= ben;
    avs_write <= wr;
    avs_read <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      num_errors++;
      complete_run();
    end
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic push(output logic [31:0] w0, output logic [31:0] w1, output logic [31:0] w2);
    sample_push <= 1'b1;
    @(posedge clock);
    sample_push <= 1'b0;
    @(posedge clock);
    check("stream_valid", 32'h1, {31'h0, stream_valid}, 0);
    w0 = stream_tach0;
    w1 = stream_tach1;
    w2 = stream_gate;
  endtask : push
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    do_reset();
    bus(1'b0, tgem_pkg::OFS_CTRL, 32'h0, 4'hf, rd);
    check("ctrl reset", 32'h0, rd, 0);
    ctrl_m = 16'h0000;
    for (i = 0; i < 8; i++) begin
      wd = $random(seed);
      be = 4'($random(seed));
      bus(1'b1, tgem_pkg::OFS_CTRL, wd, be, rd);
      if (be[0]) ctrl_m[7:0] = wd[7:0];
      if (be[1]) ctrl_m[15:8] = wd[15:8];
      ctrl_m = ctrl_m & tgem_pkg::CTRL_MASK;
      bus(1'b0, tgem_pkg::OFS_CTRL, 32'h0, 4'hf, rd);
      check("ctrl", {16'h0, ctrl_m}, rd, 0);
    end
    bus(1'b0, 5'h14, 32'h0, 4'hf, rd);
    check("unmapped", 32'h0, rd, 0);
    bus(1'b1, tgem_pkg::OFS_CTRL, 32'hffff, 4'hf, rd);
    do_reset();
    bus(1'b0, tgem_pkg::OFS_CTRL, 32'h0, 4'hf, rd);
    check("ctrl after reset", 32'h0, rd, 0);
    for (i = 0; i < 6; i++) begin
      wd = 32'(t1_start[i] << 14 | gate_start[i] << 12 | t1_stop[i] << 6 | (i != 2) << 4
        | i[2] << 3 | i[1] << 1 | i[0]);
      bus(1'b1, tgem_pkg::OFS_CTRL, wd, 4'hf, rd);
      run <= 1'b1;
      repeat (270) @(posedge clock);
      run <= 1'b0;
      repeat (10) @(posedge clock);
      push(t0, t1, g);
      check("tach0 count", cnt_of(100), {1'b0, t0[30:0]}, 1);
      check("tach0 fresh msb", 32'h0, {31'h0, t0[31]}, 0);
      check("tach1", cnt_of(t1_clocks[i]), t1, t1_clocks[i] != 0);
      check("gate", cnt_of(gate_clocks[i]), g, 1);
      push(t0b, t1b, gb);
      check("tach0 stale", {i[0], i[1] ? 31'h0 : t0[30:0]}, t0b, 0);
      check("tach1 clear", (i != 2) ? 32'h0 : t1, t1b, 0);
      bus(1'b0, tgem_pkg::OFS_TACH0, 32'h0, 4'hf, rd);
      check("tach0 reg", {i[0], i[1] ? 31'h0 : t0[30:0]}, rd, 0);
      bus(1'b0, tgem_pkg::OFS_TACH1, 32'h0, 4'hf, rd);
      check("tach1 reg", (i != 2) ? 32'h0 : t1, rd, 0);
      bus(1'b0, tgem_pkg::OFS_GATE, 32'h0, 4'hf, rd);
      check("gate reg", g, rd, 0);
      bus(1'b0, tgem_pkg::OFS_STATUS, 32'h0, 4'hf, rd);
      wd = 32'(1 << tgem_pkg::ST_T0_RUN_BIT | t1_run[i] << tgem_pkg::ST_T1_RUN_BIT
        | gate_run[i] << tgem_pkg::ST_GATE_RUN_BIT);
      check("status", wd, rd, 0);
    end
    complete_run();
  end
endmodule : tach_gate_edge_measure_bench
`default_nettype wire
